// file: src/dsu_consts.vh
// Constants for the debug serial port: register map, fields, timing
`ifndef DSU_CONSTS_VH
`define DSU_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets in the processor register space
// ----------------------------------------------------------------------
`define DSU_ADDR_FLAGS 16'hc028
`define DSU_ADDR_BYTE_LOW 16'hc029
`define DSU_ADDR_BYTE_HIGH 16'hc02a
`define DSU_ADDR_DIVIDER 16'hc02b

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define DSU_FLAG_OVERRUN 3
`define DSU_FLAG_RX_FULL 2
`define DSU_FLAG_TX_FULL 1
`define DSU_FLAG_TX_SHIFTING 0

// ----------------------------------------------------------------------
// Divider fields and reset values
// ----------------------------------------------------------------------
`define DSU_PRESCALE_MSB 15
`define DSU_PRESCALE_LSB 8
`define DSU_BIT_TIME_MSB 7
`define DSU_BIT_TIME_LSB 0
`define DSU_DIVIDER_RESET 16'h0000
`define DSU_BYTE_RESET 8'h00
`define DSU_READ_ZERO 16'h0000

// ----------------------------------------------------------------------
// Frame shape
// ----------------------------------------------------------------------
`define DSU_FRAME_BITS 4'ha
`define DSU_DATA_BITS 4'h8

`endif

// file: src/dsu_prescaler.v
// First divider: one tick every (prescale + 1) master clocks
`timescale 1ns/1ps
`default_nettype none

module dsu_prescaler
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Divide setting
  input wire [7:0] prescale,
  // Tick out, one clock wide
  output reg tick
);

  reg [7:0] count;

  // ----------------------------------------------------------------------
  // Counter and tick
  // ----------------------------------------------------------------------

  // Count 0..prescale, tick on wrap
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= 8'h00;
      tick <= 1'b0;
    end
    else if (count >= prescale)
    begin
      count <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: src/dsu_uart.v
// Debug serial port: register slave, transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
`include "dsu_consts.vh"

module dsu_uart
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Processor register port
  input wire [15:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [15:0] reg_write_data,
  output reg [15:0] reg_read_data,
  // Serial line
  input wire serial_in,
  output reg serial_out,
  // Interrupt requests, one clock wide
  output reg transmit_irq,
  output reg receive_irq
);

  // Receiver states
  localparam [2:0] RX_IDLE = 3'd0;
  localparam [2:0] RX_START = 3'd1;
  localparam [2:0] RX_DATA = 3'd2;
  localparam [2:0] RX_STOP = 3'd3;
  localparam [2:0] RX_WAIT_HIGH = 3'd4;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg [15:0] bit_rate_divider;
  reg [7:0] rx_holding;
  reg rx_holding_full_flag;
  reg rx_overrun_flag;
  reg [7:0] tx_holding;
  reg tx_holding_full_flag;
  reg tx_shifting_flag;
  reg [9:0] tx_shift;
  reg [3:0] tx_bit_count;
  reg [7:0] tx_tick_count;
  reg rx_sync_a;
  reg rx_sync_b;
  reg rx_prev;
  reg [2:0] rx_state;
  reg [7:0] rx_tick_count;
  reg [3:0] rx_bit_count;
  reg [7:0] rx_shift;
  reg rx_transfer;
  wire tick;
  wire [7:0] prescale_divider;
  wire [7:0] bit_time_divider;
  wire sel_low;
  wire sel_high;
  wire data_write;
  wire data_read;
  wire [7:0] write_byte;
  wire tx_bit_end;
  wire tx_frame_end;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // True when a tick count has run through its full span
  function span_done;
    input [7:0] count;
    input [7:0] span;
    begin
      span_done = ((count + 8'h01) >= span);
    end
  endfunction

  // Build a whole frame around a data byte
  function [9:0] make_frame;
    input [7:0] data;
    begin
      make_frame = {1'b1, data, 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Divider fields and prescaler
  // ----------------------------------------------------------------------
  assign prescale_divider =
    bit_rate_divider[`DSU_PRESCALE_MSB:`DSU_PRESCALE_LSB];
  assign bit_time_divider =
    bit_rate_divider[`DSU_BIT_TIME_MSB:`DSU_BIT_TIME_LSB];

  // First divider; its tick paces both directions
  dsu_prescaler u_prescaler
  (
    .clk(clk),
    .reset_n(reset_n),
    .prescale(prescale_divider),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  assign sel_low = (reg_addr == `DSU_ADDR_BYTE_LOW);
  assign sel_high = (reg_addr == `DSU_ADDR_BYTE_HIGH);
  assign data_write = reg_write && (sel_low || sel_high);
  assign data_read = reg_read && (sel_low || sel_high);
  // Byte lane picked by which data register is addressed
  assign write_byte = sel_high ? reg_write_data[15:8]
                               : reg_write_data[7:0];

  // Divider register
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bit_rate_divider <= `DSU_DIVIDER_RESET;
    else if (reg_write && reg_addr == `DSU_ADDR_DIVIDER)
      bit_rate_divider <= reg_write_data;
  end

  // Read data, registered; valid the clock after the read strobe
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_read_data <= `DSU_READ_ZERO;
    else if (reg_read)
    begin
      case (reg_addr)
        `DSU_ADDR_FLAGS:
          reg_read_data <= {12'h000, rx_overrun_flag, rx_holding_full_flag,
                            tx_holding_full_flag, tx_shifting_flag};
        `DSU_ADDR_BYTE_LOW:
          reg_read_data <= {8'h00, rx_holding};
        `DSU_ADDR_BYTE_HIGH:
          reg_read_data <= {rx_holding, 8'h00};
        `DSU_ADDR_DIVIDER:
          reg_read_data <= bit_rate_divider;
        default:
          reg_read_data <= `DSU_READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  assign tx_bit_end =
    tick && span_done(tx_tick_count, bit_time_divider);
  assign tx_frame_end = tx_bit_end && (tx_bit_count == `DSU_FRAME_BITS - 4'h1);

  // Holding register, shifter, bit timing and transmit interrupt
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_holding <= `DSU_BYTE_RESET;
      tx_holding_full_flag <= 1'b0;
      tx_shifting_flag <= 1'b0;
      tx_shift <= 10'h3ff;
      tx_bit_count <= 4'h0;
      tx_tick_count <= 8'h00;
      transmit_irq <= 1'b0;
    end
    else
    begin
      transmit_irq <= 1'b0;
      if (data_write && !tx_shifting_flag)
      begin
        // Idle: straight into the shifter
        tx_shift <= make_frame(write_byte);
        tx_shifting_flag <= 1'b1;
        tx_bit_count <= 4'h0;
        tx_tick_count <= 8'h00;
        transmit_irq <= 1'b1;
      end
      else
      begin
        if (data_write)
        begin
          // Busy: park the byte until the frame ends
          tx_holding <= write_byte;
          tx_holding_full_flag <= 1'b1;
        end
        if (tx_shifting_flag && tick)
        begin
          if (tx_bit_end)
            tx_tick_count <= 8'h00;
          else
            tx_tick_count <= tx_tick_count + 8'h01;
        end
        if (tx_shifting_flag && tx_frame_end)
        begin
          if (tx_holding_full_flag && !data_write)
          begin
            // Next queued byte starts at once
            tx_shift <= make_frame(tx_holding);
            tx_holding_full_flag <= 1'b0;
            tx_bit_count <= 4'h0;
            transmit_irq <= 1'b1;
          end
          else if (data_write)
          begin
            // Byte written in the last bit's final clock
            tx_shift <= make_frame(write_byte);
            tx_holding_full_flag <= 1'b0;
            tx_bit_count <= 4'h0;
            transmit_irq <= 1'b1;
          end
          else
          begin
            tx_shifting_flag <= 1'b0;
            tx_shift <= 10'h3ff;
          end
        end
        else if (tx_shifting_flag && tx_bit_end)
        begin
          // Next bit, least significant first
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_bit_count <= tx_bit_count + 4'h1;
        end
      end
    end
  end

  // Line driver; high whenever nothing is shifting
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      serial_out <= 1'b1;
    else if (tx_shifting_flag)
      serial_out <= tx_shift[0];
    else
      serial_out <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------

  // Two-stage synchroniser for the serial input
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_sync_a <= 1'b1;
      rx_sync_b <= 1'b1;
    end
    else
    begin
      rx_sync_a <= serial_in;
      rx_sync_b <= rx_sync_a;
    end
  end

  // Frame sequencer running on prescaler ticks
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_tick_count <= 8'h00;
      rx_bit_count <= 4'h0;
      rx_shift <= `DSU_BYTE_RESET;
      rx_transfer <= 1'b0;
    end
    else
    begin
      rx_transfer <= 1'b0;
      if (tick)
      begin
        rx_prev <= rx_sync_b;
        case (rx_state)
          RX_IDLE:
          begin
            rx_tick_count <= 8'h00;
            // Falling edge marks a start bit
            if (rx_prev && !rx_sync_b)
              rx_state <= RX_START;
          end
          RX_START:
          begin
            // Half a bit on to reach mid start bit
            if (span_done(rx_tick_count, {1'b0, bit_time_divider[7:1]}))
            begin
              rx_tick_count <= 8'h00;
              rx_bit_count <= 4'h0;
              if (rx_sync_b)
                rx_state <= RX_IDLE;
              else
                rx_state <= RX_DATA;
            end
            else
              rx_tick_count <= rx_tick_count + 8'h01;
          end
          RX_DATA:
          begin
            if (span_done(rx_tick_count, bit_time_divider))
            begin
              rx_tick_count <= 8'h00;
              rx_shift <= {rx_sync_b, rx_shift[7:1]};
              rx_bit_count <= rx_bit_count + 4'h1;
              if (rx_bit_count == `DSU_DATA_BITS - 4'h1)
                rx_state <= RX_STOP;
            end
            else
              rx_tick_count <= rx_tick_count + 8'h01;
          end
          RX_STOP:
          begin
            if (span_done(rx_tick_count, bit_time_divider))
            begin
              rx_tick_count <= 8'h00;
              if (rx_sync_b)
              begin
                rx_transfer <= 1'b1;
                rx_state <= RX_IDLE;
              end
              else
                rx_state <= RX_WAIT_HIGH;
            end
            else
              rx_tick_count <= rx_tick_count + 8'h01;
          end
          RX_WAIT_HIGH:
          begin
            // Bad frame dropped; resume once the line is high
            if (rx_sync_b)
              rx_state <= RX_IDLE;
          end
          default:
            rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Holding register, flags and receive interrupt
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_holding <= `DSU_BYTE_RESET;
      rx_holding_full_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      receive_irq <= 1'b0;
    end
    else
    begin
      receive_irq <= 1'b0;
      if (rx_transfer)
      begin
        rx_holding <= rx_shift;
        // Old full state, less a read in this very clock
        rx_overrun_flag <= rx_holding_full_flag && !data_read;
        rx_holding_full_flag <= 1'b1;
        receive_irq <= 1'b1;
      end
      else if (data_read)
        rx_holding_full_flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: testbench/dsu_uart_checker.sv
// Assertion checker for the debug serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "dsu_consts.vh"

module dsu_uart_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_write_data,
  input wire logic [15:0] reg_read_data,
  // Serial lines and interrupts
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic transmit_irq,
  input wire logic receive_irq
);
  logic rx_pend;
  wire logic rd_flags = reg_read && reg_addr == `DSU_ADDR_FLAGS;
  wire logic rd_low = reg_read && reg_addr == `DSU_ADDR_BYTE_LOW;
  wire logic rd_high = reg_read && reg_addr == `DSU_ADDR_BYTE_HIGH;
  wire logic full_now = rx_pend | receive_irq;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Unread received byte as seen from the ports; a data read wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_pend <= 1'b0;
    else if (rd_low || rd_high)
      rx_pend <= 1'b0;
    else if (receive_irq)
      rx_pend <= 1'b1;
  end

  // Register reads
  flags_width_a:
    assert property (rd_flags |=> reg_read_data[15:4] == 12'h000)
      else $error("status read has upper bits set");
  rx_full_flag_a:
    assert property (rd_flags |=> reg_read_data[2] == $past(full_now))
      else $error("receive full flag wrong");
  low_read_zero_a:
    assert property (rd_low |=> reg_read_data[15:8] == 8'h00)
      else $error("low data read has upper byte set");
  high_read_zero_a:
    assert property (rd_high |=> reg_read_data[7:0] == 8'h00)
      else $error("high data read has lower byte set");

  // Interrupt pulses and line timing
  // Stop level seen by the receiver: pin, two sync stages, transfer, irq
  stop_high_rx_a:
    assert property (receive_irq |-> $past(serial_in, 4))
      else $error("receive interrupt without a high stop bit");
  rx_irq_pulse_a:
    assert property (receive_irq |=> !receive_irq)
      else $error("receive interrupt longer than one clock");
  tx_irq_pulse_a:
    assert property (transmit_irq |=> !transmit_irq)
      else $error("transmit interrupt longer than one clock");
  start_after_load_a:
    assert property (transmit_irq |=> !serial_out)
      else $error("start bit not one clock after load");
  low_bit_len_a:
    assert property ($fell(serial_out) |-> (!serial_out)[*6])
      else $error("low bit shorter than six clocks");
  high_bit_len_a:
    assert property ($rose(serial_out) |-> serial_out[*6])
      else $error("high bit shorter than six clocks");

  // Main scenarios
  cover property (transmit_irq);
  cover property (receive_irq && rx_pend);
  cover property (rd_flags && full_now);
endmodule

bind dsu_uart dsu_uart_checker u_chk
(
  .clk(clk),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_write_data(reg_write_data),
  .reg_read_data(reg_read_data),
  .serial_in(serial_in),
  .serial_out(serial_out),
  .transmit_irq(transmit_irq),
  .receive_irq(receive_irq)
);
`default_nettype wire

// file: testbench/dsu_host.sv
// Remote serial host model: sends frames in, decodes frames out
`timescale 1ns/1ps
`default_nettype none

module dsu_host
(
  // Line into the port receiver
  output var logic line_out,
  // Line from the port transmitter
  input wire logic line_in
);
  int bit_ns = 48;
  logic [8:0] frame;
  logic [8:0] got_q[$];

  // Line rests high between frames
  initial
    line_out = 1'b1;

  // One frame, stop level chosen by the caller
  task automatic send(input logic [7:0] data, input logic stop);
    line_out = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++)
    begin
      line_out = data[i];
      #(bit_ns);
    end
    line_out = stop;
    #(bit_ns);
    // One idle bit so back-to-back frames never glitch the line
    line_out = 1'b1;
    #(bit_ns);
  endtask

  // Sample mid-bit, stop level kept in bit 8
  always
  begin
    @(negedge line_in);
    #(bit_ns / 2);
    for (int i = 0; i < 9; i++)
    begin
      #(bit_ns);
      frame[i] = line_in;
    end
    got_q.push_back(frame);
  end
endmodule
`default_nettype wire

// file: testbench/dsu_uart_tb_top.sv
// Self-checking bench for the debug serial port
`timescale 1ns/1ps
`default_nettype none
`include "dsu_consts.vh"

module dsu_uart_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_write_data = 16'h0000;
  wire logic [15:0] reg_read_data;
  wire logic serial_in;
  wire logic serial_out;
  wire logic transmit_irq;
  wire logic receive_irq;
  int n_errors = 0;
  int n_tests = 0;
  int n_tx = 0;
  int n_rx = 0;
  int cycles = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  dsu_uart DUT
  (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .transmit_irq(transmit_irq),
    .receive_irq(receive_irq)
  );

  dsu_host host
  (
    .line_out(serial_in),
    .line_in(serial_out)
  );

  // Interrupt pulse counts and hang guard
  always @(posedge clk)
  begin
    if (transmit_irq === 1'b1)
      n_tx = n_tx + 1;
    if (receive_irq === 1'b1)
      n_rx = n_rx + 1;
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_write_data = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    chk(reg_read_data, exp);
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; bit time is (1 + 1) * 6 clocks = 48 ns
  initial
  begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    rd(`DSU_ADDR_FLAGS, 16'h0000);
    rd(`DSU_ADDR_DIVIDER, 16'h0000);
    rd(`DSU_ADDR_BYTE_HIGH, 16'h0000);
    wr(`DSU_ADDR_FLAGS, 16'hffff);
    rd(`DSU_ADDR_FLAGS, 16'h0000);
    rd(16'hc02c, 16'h0000);
    wr(`DSU_ADDR_DIVIDER, 16'h0106);
    rd(`DSU_ADDR_DIVIDER, 16'h0106);
    // Second byte waits behind the first
    wr(`DSU_ADDR_BYTE_LOW, 16'hff5a);
    wr(`DSU_ADDR_BYTE_HIGH, 16'ha5c3);
    rd(`DSU_ADDR_FLAGS, 16'h0003);
    chk(n_tx[15:0], 16'h0001);
    for (int i = 0; i < 3000 && host.got_q.size() < 2; i++)
      @(negedge clk);
    repeat (20) @(negedge clk);
    chk({7'h00, host.got_q[0]}, 16'h015a);
    chk({7'h00, host.got_q[1]}, 16'h01a5);
    chk(n_tx[15:0], 16'h0002);
    rd(`DSU_ADDR_FLAGS, 16'h0000);
    // Receive, overrun and a dropped frame
    host.send(8'h3c, 1'b1);
    repeat (4) @(negedge clk);
    chk(n_rx[15:0], 16'h0001);
    rd(`DSU_ADDR_FLAGS, 16'h0004);
    rd(`DSU_ADDR_BYTE_LOW, 16'h003c);
    rd(`DSU_ADDR_FLAGS, 16'h0000);
    host.send(8'hc3, 1'b1);
    host.send(8'h81, 1'b1);
    repeat (4) @(negedge clk);
    rd(`DSU_ADDR_FLAGS, 16'h000c);
    rd(`DSU_ADDR_BYTE_HIGH, 16'h8100);
    rd(`DSU_ADDR_FLAGS, 16'h0008);
    host.send(8'h66, 1'b0);
    repeat (20) @(negedge clk);
    rd(`DSU_ADDR_FLAGS, 16'h0008);
    chk(n_rx[15:0], 16'h0003);
    host.send(8'h11, 1'b1);
    repeat (4) @(negedge clk);
    rd(`DSU_ADDR_FLAGS, 16'h0004);
    rd(`DSU_ADDR_BYTE_LOW, 16'h0011);
    tally_and_finish();
  end
endmodule
`default_nettype wire
